// ### rwl_guard.sv
// Combinational decoder that spots writes to the guarded configuration register.
// Assumes address and strobe are synchronous to the caller's clock.
`timescale 1ns/1ps
`include "rwl_regs.svh"
module rwl_guard
  import rwl_pkg::*;
(
  // Bus side
  input wire logic wr_in,
  input wire logic [31:0] addr_in,
  input wire logic armed_in,
  // Result
  output logic cfg_we_out,
  rwl_viol_if.src viol
);
  logic is_cfg;
  always_comb begin
    is_cfg = (addr_in == `RWL_OFF_CFG);
    cfg_we_out = wr_in && is_cfg && !armed_in;
    viol.hit = wr_in && is_cfg && armed_in;
    viol.offset = 16'(addr_in - `RWL_BASE);
  end
endmodule : rwl_guard

// ### rwl_pkg.sv
// Types shared by the register write lock files.
// Assumes the constants header is included by each user.
package rwl_pkg;
  typedef enum logic [1:0] {
    RWL_OPEN = 2'b00,
    RWL_ARMED = 2'b01
  } rwl_state_t;
endpackage : rwl_pkg

// ### rwl_regs.svh
// Register offsets, field positions, reset values and key for the register write lock.
// Assumes byte addresses on a plain 32-bit register port.
`ifndef RWL_REGS_SVH
`define RWL_REGS_SVH
`define RWL_ADDR_W 32
`define RWL_OFF_CFG 32'h40080054
`define RWL_OFF_MODE 32'h400800E4
`define RWL_OFF_STATUS 32'h400800E8
`define RWL_OFF_IRQ_STAT 32'h400800F0
`define RWL_OFF_IRQ_MASK 32'h400800F4
`define RWL_BASE 32'h40080000
`define RWL_KEY 24'h4D4349
`define RWL_KEY_LSB 8
`define RWL_KEY_MSB 31
`define RWL_EN_BIT 0
`define RWL_VFLAG_BIT 0
`define RWL_VSRC_LSB 8
`define RWL_VSRC_MSB 23
`define RWL_CFG_MASK 32'h00001111
`define RWL_CFG_RESET 32'h00000000
`endif

// ### rwl_top.sv
// Register write lock: keyed protection of the card host configuration register.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
// Notes on behaviour
// - Enable bit one with correct key in one write arms protection.
// - Enable bit zero with correct key in one write disarms protection.
// - Wrong key leaves enable unchanged; key field always reads zero.
// - Violation flag bit 0 sets on violation, clears when status is read.
// - Offending register offset captured in status bits 8 to 23.
// - Configuration register writes ignored while protection is armed.
`timescale 1ns/1ps
`include "rwl_regs.svh"
module rwl_top
  import rwl_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Block outputs
  output logic [31:0] cfg_out,
  output logic protect_enable_out,
  output logic irq_out
);
  rwl_state_t state_reg, state_next;
  logic [31:0] cfg_reg, cfg_next;
  logic violation_flag_reg, violation_flag_next;
  logic [15:0] violation_source_offset_reg, violation_source_offset_next;
  logic irq_stat_reg, irq_stat_next;
  logic irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  logic protect_enable_reg, protect_enable_next;
  logic [31:0] rdata_reg, rdata_next;
  logic cfg_we;
  logic key_ok;
  rwl_viol_if viol_bus ();

  rwl_guard u_guard (
    .wr_in(wr_in),
    .addr_in(addr_in),
    .armed_in(state_reg == RWL_ARMED),
    .cfg_we_out(cfg_we),
    .viol(viol_bus.src)
  );

  assign key_ok = (wdata_in[`RWL_KEY_MSB:`RWL_KEY_LSB] == `RWL_KEY);

  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    violation_flag_next = violation_flag_reg;
    violation_source_offset_next = violation_source_offset_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next = 32'h00000000;
    if (wr_in && addr_in == `RWL_OFF_MODE && key_ok) begin
      state_next = wdata_in[`RWL_EN_BIT] ? RWL_ARMED : RWL_OPEN;
    end
    if (cfg_we) begin
      cfg_next = wdata_in & `RWL_CFG_MASK;
    end
    if (rd_in) begin
      case (addr_in)
        `RWL_OFF_CFG: rdata_next = cfg_reg;
        `RWL_OFF_MODE: rdata_next = {31'h00000000, state_reg == RWL_ARMED};
        `RWL_OFF_STATUS: begin
          rdata_next = {8'h00, violation_source_offset_reg, 7'h00, violation_flag_reg};
          violation_flag_next = 1'b0;
        end
        `RWL_OFF_IRQ_STAT: rdata_next = {31'h00000000, irq_stat_reg};
        `RWL_OFF_IRQ_MASK: rdata_next = {31'h00000000, irq_mask_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    if (wr_in && addr_in == `RWL_OFF_IRQ_STAT && wdata_in[0]) begin
      irq_stat_next = 1'b0;
    end
    if (wr_in && addr_in == `RWL_OFF_IRQ_MASK) begin
      irq_mask_next = wdata_in[0];
    end
    // Set wins over a clear in the same cycle so no violation is lost.
    if (viol_bus.hit) begin
      violation_flag_next = 1'b1;
      violation_source_offset_next = viol_bus.offset;
      irq_stat_next = 1'b1;
    end
    irq_next = irq_stat_next && irq_mask_next;
    protect_enable_next = (state_next == RWL_ARMED);
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_reg <= RWL_OPEN;
      cfg_reg <= `RWL_CFG_RESET;
      violation_flag_reg <= 1'b0;
      violation_source_offset_reg <= 16'h0000;
      irq_stat_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
      irq_reg <= 1'b0;
      protect_enable_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      violation_flag_reg <= violation_flag_next;
      violation_source_offset_reg <= violation_source_offset_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      protect_enable_reg <= protect_enable_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign cfg_out = cfg_reg;
  assign protect_enable_out = protect_enable_reg;
  assign irq_out = irq_reg;

  property p_arm;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == `RWL_OFF_MODE && key_ok && wdata_in[0]) |=> protect_enable_out;
  endproperty
  a_arm: assert property (p_arm) else $error("protection not armed");

  property p_disarm;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == `RWL_OFF_MODE && key_ok && !wdata_in[0]) |=> !protect_enable_out;
  endproperty
  a_disarm: assert property (p_disarm) else $error("protection not disarmed");

  property p_badkey;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == `RWL_OFF_MODE && !key_ok) |=> $stable(protect_enable_out);
  endproperty
  a_badkey: assert property (p_badkey) else $error("wrong key changed enable");

  property p_keyread;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (rd_in && addr_in == `RWL_OFF_MODE) |=> rdata_out[31:8] == 24'h000000;
  endproperty
  a_keyread: assert property (p_keyread) else $error("key field read nonzero");

  sequence s_violate;
    wr_in && addr_in == `RWL_OFF_CFG && protect_enable_out;
  endsequence
  sequence s_read_clean;
    rd_in && addr_in == `RWL_OFF_STATUS && !(wr_in && addr_in == `RWL_OFF_CFG);
  endsequence

  property p_flagset;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_violate |=> violation_flag_reg;
  endproperty
  a_flagset: assert property (p_flagset) else $error("violation flag not set");

  property p_flagclr;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (s_read_clean ##1 !(wr_in && addr_in == `RWL_OFF_CFG && protect_enable_out))
        |=> !violation_flag_reg;
  endproperty
  a_flagclr: assert property (p_flagclr) else $error("flag not cleared by read");

  property p_source;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_violate |=> violation_source_offset_reg == 16'h0054;
  endproperty
  a_source: assert property (p_source) else $error("wrong violation offset");

  property p_locked;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_violate |=> $stable(cfg_out);
  endproperty
  a_locked: assert property (p_locked) else $error("locked config changed");

  property p_open;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == `RWL_OFF_CFG && !protect_enable_out)
        |=> cfg_out == ($past(wdata_in) & `RWL_CFG_MASK);
  endproperty
  a_open: assert property (p_open) else $error("open config write lost");

  sequence s_status_read;
    rd_in && addr_in == `RWL_OFF_STATUS;
  endsequence

  property p_stat_flag;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_status_read |=> rdata_out[0] == $past(violation_flag_reg);
  endproperty
  a_stat_flag: assert property (p_stat_flag) else $error("status flag read wrong");

  property p_stat_src;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_status_read |=> rdata_out[23:8] == $past(violation_source_offset_reg);
  endproperty
  a_stat_src: assert property (p_stat_src) else $error("status offset read wrong");

  property p_mode_read;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (rd_in && addr_in == `RWL_OFF_MODE) |=> rdata_out[0] == $past(protect_enable_out);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("enable read wrong");

  // Read data must not linger, or software polling an unmapped slot sees stale values.
  property p_rdidle;
    @(posedge mclk_in) disable iff (sys_rst_in)
      !rd_in |=> rdata_out == 32'h00000000;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data not zero when idle");

  property p_irqset;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_violate |=> irq_stat_reg;
  endproperty
  a_irqset: assert property (p_irqset) else $error("violation event not latched");

  property p_irq;
    @(posedge mclk_in) disable iff (sys_rst_in)
      irq_out == (irq_stat_reg && irq_mask_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule : rwl_top

// ### rwl_viol_if.sv
// Carries a refused-write event from the guard decoder to the top.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface rwl_viol_if;
  logic hit;
  logic [15:0] offset;
  modport src (output hit, output offset);
  modport dst (input hit, input offset);
endinterface : rwl_viol_if

// ### tb_top.sv
// Self-checking bench for the register write lock top.
// Assumes the constants header and all design files are compiled ahead of it.
`timescale 1ns/1ps
`include "rwl_regs.svh"
module tb_top;
  import rwl_pkg::*;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [31:0] cfg_out;
  logic protect_enable_out;
  logic irq_out;
  logic rd_q = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] cv;
  int fails = 0;
  int tests_run = 0;
  localparam logic [31:0] KW = {`RWL_KEY, 8'h00};
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  rwl_top dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .cfg_out(cfg_out), .protect_enable_out(protect_enable_out), .irq_out(irq_out));
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask : op
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    op(1'b0, a, 32'h0);
  endtask : rd
  // Two falling edges let registered outputs one cycle behind their cause land.
  task automatic settle();
    repeat (2) @(negedge mclk_in);
  endtask : settle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge mclk_in) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        chk("read queue", 32'h1, 32'h0);
      end else begin
        chk("rdata_out", exp_q.pop_front(), rdata_out & msk_q.pop_front());
      end
    end
    rd_q <= rd_in;
  end
  // The sequence needs about 75 cycles; 2500 leaves a wide margin.
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(19));
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(`RWL_OFF_MODE, 32'h0, ALL);
    rd(`RWL_OFF_STATUS, 32'h0, 32'h1);
    settle();
    chk("protect_enable_out", 32'h0, {31'h0, protect_enable_out});
    $display("test reset done");
    cv = $urandom();
    op(1'b1, `RWL_OFF_CFG, cv);
    op(1'b1, `RWL_OFF_MODE, {24'h4D4348, 8'h01});
    rd(`RWL_OFF_CFG, cv & `RWL_CFG_MASK, ALL);
    rd(32'h40080010, 32'h0, ALL);
    settle();
    chk("cfg_out", cv & `RWL_CFG_MASK, cfg_out);
    chk("protect_enable_out", 32'h0, {31'h0, protect_enable_out});
    $display("test open done");
    op(1'b1, `RWL_OFF_IRQ_MASK, 32'h1);
    op(1'b1, `RWL_OFF_MODE, KW | 32'h1);
    rd(`RWL_OFF_MODE, 32'h1, ALL);
    op(1'b1, `RWL_OFF_CFG, ~cv);
    op(1'b1, `RWL_OFF_CFG, ~cv);
    settle();
    chk("cfg_out", cv & `RWL_CFG_MASK, cfg_out);
    chk("irq_out", 32'h1, {31'h0, irq_out});
    rd(`RWL_OFF_STATUS, 32'h00005401, ALL);
    rd(`RWL_OFF_STATUS, 32'h0, 32'h1);
    op(1'b1, `RWL_OFF_MODE, 32'h0);
    op(1'b1, `RWL_OFF_IRQ_STAT, 32'h1);
    settle();
    chk("protect_enable_out", 32'h1, {31'h0, protect_enable_out});
    chk("irq_out", 32'h0, {31'h0, irq_out});
    $display("test armed done");
    op(1'b1, `RWL_OFF_IRQ_MASK, 32'h0);
    op(1'b1, `RWL_OFF_CFG, 32'h0);
    settle();
    chk("irq_out", 32'h0, {31'h0, irq_out});
    op(1'b1, `RWL_OFF_IRQ_MASK, 32'h1);
    settle();
    chk("irq_out", 32'h1, {31'h0, irq_out});
    rd(`RWL_OFF_IRQ_STAT, 32'h1, ALL);
    rd(`RWL_OFF_IRQ_MASK, 32'h1, ALL);
    op(1'b1, `RWL_OFF_IRQ_STAT, 32'h1);
    settle();
    chk("irq_out", 32'h0, {31'h0, irq_out});
    $display("test irq done");
    op(1'b1, `RWL_OFF_MODE, KW);
    op(1'b1, `RWL_OFF_CFG, ~cv);
    rd(`RWL_OFF_STATUS, 32'h00005401, ALL);
    rd(`RWL_OFF_STATUS, 32'h0, 32'h1);
    settle();
    chk("protect_enable_out", 32'h0, {31'h0, protect_enable_out});
    chk("cfg_out", ~cv & `RWL_CFG_MASK, cfg_out);
    $display("test disarm done");
    repeat (3) @(posedge mclk_in);
    end_sim();
  end
endmodule : tb_top
